// file: reset_source_pkg.sv
// constants, types and reset state of the reset source controller
package reset_source_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 40;
    localparam int MCD_MIN_US      = 100;
    localparam int MCD_TYP_US      = 220;
    localparam int MCD_MAX_US      = 500;
    localparam int MCD_TYP_CYC     = MCD_TYP_US * 1000 / CLK_PERIOD_NS;
    localparam int RESET_DELAY_NS  = 5000;
    localparam int RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_LOW_MIN_NS  = 15000;
    localparam int PIN_LOW_CYC     = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDT_DIV         = 12;

    localparam logic [7:0]  DELAY_LAST = 8'(RESET_DELAY_CYC - 1);
    localparam logic [15:0] PIN_LAST   = 16'(PIN_LOW_CYC - 1);
    localparam logic [3:0]  DIV_LAST   = 4'(WDT_DIV - 1);

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_INDEX = 8'hff;
    localparam logic [9:0] REG_ADDR  = {REG_INDEX, 2'b00};

    localparam int BIT_PIN   = 0;
    localparam int BIT_POR   = 1;
    localparam int BIT_MCD   = 2;
    localparam int BIT_WDT   = 3;
    localparam int BIT_SW    = 4;
    localparam int BIT_CMP   = 5;
    localparam int BIT_FLASH = 6;

    localparam logic [15:0] LIMIT_8K = 16'h1dff;
    localparam logic [15:0] LIMIT_4K = 16'h0fff;
    localparam logic [15:0] LIMIT_2K = 16'h07ff;

    // synchroniser lanes
    localparam int SYN_PIN = 0;
    localparam int SYN_CMP = 1;
    localparam int SYN_VDD = 2;
    localparam int SYN_ACT = 3;
    localparam logic [3:0] SYN_IDLE = 4'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        read;
        logic        write;
        logic [9:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avmm_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avmm_rsp_type;

    typedef struct packed {
        logic        movx_write;
        logic        prog_write_en;
        logic [15:0] movx_addr;
        logic        movc_read;
        logic [15:0] movc_addr;
        logic        branch_fetch;
        logic [15:0] fetch_addr;
    } flash_access_type;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_RESET = 2'b10
    } rs_state_type;

    typedef struct packed {
        rs_state_type st;
        logic [6:0]   flags;
        logic         mcd_en;
        logic         cmp_en;
        logic         vdd_en;
        logic         pin_drv;
        logic [7:0]   hold;
        logic [15:0]  mcd_cnt;
        logic [15:0]  pin_cnt;
        logic [3:0]   div;
        logic [3:0]   s1;
        logic [3:0]   s2;
        logic [3:0]   s3;
        logic [3:0]   stable;
        logic         act_prev;
        logic         ack;
        logic [31:0]  rdata;
    } ctrl_state_type;

    localparam ctrl_state_type STATE_RST = '{
        st:       ST_RESET,
        flags:    7'h02,
        mcd_en:   1'b0,
        cmp_en:   1'b0,
        vdd_en:   1'b0,
        pin_drv:  1'b1,
        hold:     8'h00,
        mcd_cnt:  16'h0000,
        pin_cnt:  16'h0000,
        div:      4'h0,
        s1:       SYN_IDLE,
        s2:       SYN_IDLE,
        s3:       SYN_IDLE,
        stable:   SYN_IDLE,
        act_prev: 1'b0,
        ack:      1'b0,
        rdata:    32'h0000_0000
    };

endpackage

// file: reset_source_controller.sv
// reset source controller: combines reset requests, records the cause, runs the reset delay
`timescale 1ns/1ps

module reset_source_controller
    import reset_source_pkg::*;
#(
    parameter logic [15:0] MCD_TIMEOUT_CYC = 16'(MCD_TYP_CYC),
    parameter logic [15:0] CODE_LIMIT      = LIMIT_8K
) (
    // clock and power-on reset
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    // register bus
    input  wire reset_source_pkg::avmm_req_type     bus_req,
    output      reset_source_pkg::avmm_rsp_type     bus_rsp,
    // reset requesters
    input  wire logic                               clk_activity,
    input  wire logic                               cmp_out,
    input  wire logic                               vdd_low,
    input  wire logic                               wdt_timeout,
    input  wire reset_source_pkg::flash_access_type flash_acc,
    // external active-low reset pin
    input  wire logic                               rst_pin_n_i,
    output      logic                               rst_pin_n_o,
    output      logic                               rst_pin_n_oe,
    // system side
    output      logic                               sys_reset,
    output      logic                               vdd_mon_en,
    output      logic                               wdt_restart,
    output      logic                               wdt_tick
);
    import reset_source_pkg::*;

    ctrl_state_type r;
    ctrl_state_type n;

    logic        acc;
    logic        hit;
    logic        wr_do;
    logic [7:0]  wbyte;
    logic        pin_low;
    logic        act_edge;
    logic        mcd_req;
    logic        pin_req;
    logic        vdd_req;
    logic        vdd_en_req;
    logic        cmp_req;
    logic        flash_req;
    logic        sw_req;
    logic        hold_lvl;
    logic [6:0]  cause;

    // ------------------------------------------------------------
    // requests
    // ------------------------------------------------------------
    always_comb begin
        acc   = (bus_req.read | bus_req.write) & ~r.ack;
        hit   = bus_req.address == REG_ADDR;
        // a write lands on the edge where waitrequest is low
        wr_do = bus_req.write & r.ack & hit & bus_req.byteenable[0] & (r.st == ST_RUN);
        wbyte = bus_req.writedata[7:0];

        // our own drive of the pin must not look like an external reset
        pin_low  = ~r.stable[SYN_PIN] & ~r.pin_drv;
        pin_req  = pin_low & (r.pin_cnt == PIN_LAST);
        act_edge = r.stable[SYN_ACT] != r.act_prev;
        mcd_req  = r.mcd_en & (r.mcd_cnt == MCD_TIMEOUT_CYC - 16'h0001);
        vdd_req  = r.vdd_en & r.stable[SYN_VDD];
        vdd_en_req = wr_do & wbyte[BIT_POR] & ~r.vdd_en;
        cmp_req  = r.cmp_en & ~r.stable[SYN_CMP];
        flash_req = (flash_acc.movx_write & flash_acc.prog_write_en
                     & (flash_acc.movx_addr > CODE_LIMIT))
                  | (flash_acc.movc_read & (flash_acc.movc_addr > CODE_LIMIT))
                  | (flash_acc.branch_fetch & (flash_acc.fetch_addr > CODE_LIMIT));
        sw_req   = wr_do & wbyte[BIT_SW];

        // one-hot cause, fixed priority when several fire together
        cause = 7'h00;
        if (pin_req) begin
            cause[BIT_PIN] = 1'b1;
        end else if (vdd_req | vdd_en_req) begin
            cause[BIT_POR] = 1'b1;
        end else if (mcd_req) begin
            cause[BIT_MCD] = 1'b1;
        end else if (flash_req) begin
            cause[BIT_FLASH] = 1'b1;
        end else if (wdt_timeout) begin
            cause[BIT_WDT] = 1'b1;
        end else if (cmp_req) begin
            cause[BIT_CMP] = 1'b1;
        end else if (sw_req) begin
            cause[BIT_SW] = 1'b1;
        end

        // a low pin after a pin cause and a low supply with the monitor on keep the device in reset until they go away
        hold_lvl = (r.flags[BIT_PIN] & ~r.stable[SYN_PIN])
                 | (r.vdd_en & r.stable[SYN_VDD]);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;

        // three-stage synchronisers; a value counts when stages two and three agree
        n.s1 = {clk_activity, vdd_low, cmp_out, rst_pin_n_i};
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int i = 0; i < 4; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.stable[i] = r.s3[i];
            end
        end
        n.act_prev = r.stable[SYN_ACT];

        // pin must stay low for the minimum time before it counts
        if (pin_low) begin
            if (r.pin_cnt != PIN_LAST) begin
                n.pin_cnt = r.pin_cnt + 16'h0001;
            end
        end else begin
            n.pin_cnt = 16'h0000;
        end

        // clock activity watchdog, restarted by every clock-tree toggle
        if (act_edge | ~r.mcd_en | (r.st != ST_RUN)) begin
            n.mcd_cnt = 16'h0000;
        end else if (!mcd_req) begin
            n.mcd_cnt = r.mcd_cnt + 16'h0001;
        end

        // watchdog clock enable, restarted with the reset
        if ((r.st != ST_RUN) || (r.div == DIV_LAST)) begin
            n.div = 4'h0;
        end else begin
            n.div = r.div + 4'h1;
        end

        // bus slave: one wait cycle, read data from the flop
        n.ack = acc;
        if (acc) begin
            n.rdata = 32'h0000_0000;
            if (hit) begin
                n.rdata[6:0] = r.flags;
            end
        end

        case (r.st)
            ST_RUN: begin
                if (cause != 7'h00) begin
                    n.st      = ST_RESET;
                    n.hold    = 8'h00;
                    n.flags   = cause;
                    n.cmp_en  = 1'b0;
                    // only supply-type resets pull the pin
                    n.pin_drv = cause[BIT_POR];
                    if (vdd_en_req) begin
                        n.vdd_en = 1'b1;
                    end
                end else if (wr_do) begin
                    n.mcd_en = wbyte[BIT_MCD];
                    n.cmp_en = wbyte[BIT_CMP];
                    n.vdd_en = wbyte[BIT_POR];
                end
            end
            ST_RESET: begin
                // enables other than the comparator are left as programmed
                if (hold_lvl) begin
                    n.hold = 8'h00;
                end else if (r.hold == DELAY_LAST) begin
                    n.st      = ST_RUN;
                    n.pin_drv = 1'b0;
                end else begin
                    n.hold = r.hold + 8'h01;
                end
            end
            default: begin
                n.st = ST_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // power-on: flag set, monitor off, pin pulled low
            r <= STATE_RST;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_rsp.waitrequest = acc;
    assign bus_rsp.readdata    = r.rdata;
    assign rst_pin_n_o         = 1'b0;
    assign rst_pin_n_oe        = r.pin_drv;
    assign sys_reset           = r.st == ST_RESET;
    assign vdd_mon_en          = r.vdd_en;
    assign wdt_restart         = r.st == ST_RESET;
    assign wdt_tick            = (r.st == ST_RUN) && (r.div == DIV_LAST);

endmodule

// file: reset_source_props.sv
// checker for the reset source controller ports
`timescale 1ns/1ps
module reset_source_props
    import reset_source_pkg::*;
#(
    parameter logic [15:0] CODE_LIMIT = LIMIT_8K
) (
    // clock and reset
    input wire logic                               sys_clk,
    input wire logic                               rst,
    // bus and requests
    input wire reset_source_pkg::avmm_req_type     bus_req,
    input wire reset_source_pkg::avmm_rsp_type     bus_rsp,
    input wire logic                               wdt_timeout,
    input wire reset_source_pkg::flash_access_type flash_acc,
    // outputs
    input wire logic                               rst_pin_n_oe,
    input wire logic                               sys_reset,
    input wire logic                               vdd_mon_en,
    input wire logic                               wdt_restart,
    input wire logic                               wdt_tick
);
    logic [7:0] hi_r;
    logic [7:0] hi_nxt;
    wire        sw_wr = bus_req.write && !bus_rsp.waitrequest && bus_req.address == REG_ADDR
                        && bus_req.byteenable[0] && bus_req.writedata[BIT_SW];
    wire        bad = (flash_acc.movx_write && flash_acc.prog_write_en && flash_acc.movx_addr > CODE_LIMIT)
                      || (flash_acc.movc_read && flash_acc.movc_addr > CODE_LIMIT)
                      || (flash_acc.branch_fetch && flash_acc.fetch_addr > CODE_LIMIT);

    // cycles spent in reset, saturating so a long level cause cannot wrap it
    always_comb hi_nxt = sys_reset ? ((hi_r == 8'hff) ? hi_r : hi_r + 8'h01) : 8'h00;
    always_ff @(posedge sys_clk or posedge rst) hi_r <= rst ? 8'h00 : hi_nxt;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sw_force_a: assert property (sw_wr && !sys_reset |-> ##[1:2] sys_reset)
        else $error("software write gave no reset");
    wdt_no_pin_a: assert property (wdt_timeout && !sys_reset |=> sys_reset && !rst_pin_n_oe)
        else $error("watchdog reset wrong");
    flash_err_a: assert property (bad && !sys_reset |=> sys_reset && !rst_pin_n_oe)
        else $error("flash error reset wrong");
    reset_hold_a: assert property ($fell(sys_reset) |-> hi_r >= 8'(RESET_DELAY_CYC))
        else $error("reset released too early");
    tick_period_a: assert property (wdt_tick |=> (!wdt_tick)[*8] ##4 (wdt_tick || sys_reset))
        else $error("watchdog tick period wrong");
    restart_match_a: assert property (wdt_restart == sys_reset)
        else $error("watchdog restart differs");
    unused_bit_a: assert property (bus_req.read && !bus_rsp.waitrequest |-> bus_rsp.readdata[31:7] == '0)
        else $error("upper read bits set");
    mon_keep_a: assert property (sys_reset && !rst_pin_n_oe |-> $stable(vdd_mon_en))
        else $error("monitor enable lost");
    pin_idle_a: assert property (!sys_reset |-> !rst_pin_n_oe)
        else $error("pin driven out of reset");
endmodule

bind reset_source_controller reset_source_props #(.CODE_LIMIT(CODE_LIMIT)) i_props (.sys_clk, .rst,
    .bus_req, .bus_rsp, .wdt_timeout, .flash_acc, .rst_pin_n_oe, .sys_reset, .vdd_mon_en,
    .wdt_restart, .wdt_tick);

// file: reset_requester_model.sv
// far-side model: clock activity source and the pulled-up reset pin
`timescale 1ns/1ps
module reset_requester_model (
    // commands from the bench
    input  wire logic sys_clk,
    input  wire logic clk_run,
    input  wire logic ext_low,
    // pin driver of the controller
    input  wire logic rst_pin_n_o,
    input  wire logic rst_pin_n_oe,
    // towards the controller
    output      logic clk_activity,
    output      logic rst_pin_n_i
);
    // a stopped clock tree holds its last level
    // toggles every second edge so the controller's agreement filter can follow it
    logic phase;
    initial clk_activity = 1'b0;
    initial phase = 1'b0;
    always @(posedge sys_clk) begin
        if (clk_run) begin
            phase <= ~phase;
            if (phase) begin
                clk_activity <= ~clk_activity;
            end
        end
    end
    // pull-up wins when nobody pulls the pin low
    assign rst_pin_n_i = ((rst_pin_n_oe && !rst_pin_n_o) || ext_low) ? 1'b0 : 1'b1;
endmodule

// file: test_reset_source_controller.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ps
module test_reset_source_controller;
    import reset_source_pkg::*;
    typedef struct packed {
        logic [3:0] src;
        logic [7:0] pre;
        logic [7:0] exp;
        logic       oe;
    } row_type;
    // cause, register write first, flags and pin drive expected
    localparam row_type ROWS [10] = '{
        '{4'h0, 8'h10, 8'h10, 1'b0},
        '{4'h1, 8'h00, 8'h08, 1'b0},
        '{4'h2, 8'h00, 8'h40, 1'b0},
        '{4'h3, 8'h00, 8'h40, 1'b0},
        '{4'h4, 8'h00, 8'h40, 1'b0},
        '{4'h5, 8'h20, 8'h20, 1'b0},
        '{4'h6, 8'h04, 8'h04, 1'b0},
        '{4'h7, 8'h00, 8'h01, 1'b0},
        '{4'h0, 8'h02, 8'h02, 1'b1},
        '{4'h8, 8'h02, 8'h02, 1'b1}};
    logic             sys_clk = 1'b0;
    logic             rst = 1'b1;
    avmm_req_type     req = '0;
    avmm_rsp_type     rsp;
    flash_access_type fa = '0;
    logic             cmp_out = 1'b1;
    logic             vdd_low = 1'b0;
    logic             wdt_timeout = 1'b0;
    logic             clk_run = 1'b1;
    logic             ext_low = 1'b0;
    logic             clk_act, pin_i, pin_o, pin_oe, sys_reset, mon_en, restart, tick;
    logic [31:0]      q;
    int               n_fail = 0;
    int               n_checks = 0;
    int               cyc = 0;

    reset_source_controller #(.MCD_TIMEOUT_CYC(16'h0028)) i_dut (.sys_clk, .rst, .bus_req(req),
        .bus_rsp(rsp), .clk_activity(clk_act), .cmp_out, .vdd_low, .wdt_timeout, .flash_acc(fa),
        .rst_pin_n_i(pin_i), .rst_pin_n_o(pin_o), .rst_pin_n_oe(pin_oe), .sys_reset,
        .vdd_mon_en(mon_en), .wdt_restart(restart), .wdt_tick(tick));
    reset_requester_model i_far (.sys_clk, .clk_run, .ext_low, .rst_pin_n_o(pin_o),
        .rst_pin_n_oe(pin_oe), .clk_activity(clk_act), .rst_pin_n_i(pin_i));

    always #20 sys_clk = ~sys_clk;

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // waitrequest and read data are taken at the rising edge that ends the access
    task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        req <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: {24'h00_0000, d}};
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        rd = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (sys_reset !== lvl && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic run_row(input row_type r);
        acc(1'b1, REG_ADDR, r.pre, q);
        case (r.src)
            4'h1: wdt_timeout <= 1'b1;
            4'h2: fa <= '{movx_write: 1'b1, prog_write_en: 1'b1, movx_addr: 16'h1e00, default: '0};
            4'h3: fa <= '{movc_read: 1'b1, movc_addr: LIMIT_8K + 16'h0001, default: '0};
            4'h4: fa <= '{branch_fetch: 1'b1, fetch_addr: 16'hffff, default: '0};
            4'h5: cmp_out <= 1'b0;
            4'h6: clk_run <= 1'b0;
            4'h7: ext_low <= 1'b1;
            4'h8: vdd_low <= 1'b1;
            default: ;
        endcase
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        fa <= '0;
        wait_rst(1'b1);
        chk(pin_oe, r.oe);
        @(posedge sys_clk);
        cmp_out <= 1'b1;
        clk_run <= 1'b1;
        ext_low <= 1'b0;
        vdd_low <= 1'b0;
        wait_rst(1'b0);
        acc(1'b0, REG_ADDR, 8'h00, q);
        chk(q, {24'h00_0000, r.exp});
        $display("cause %0d done", r.src);
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        acc(1'b0, REG_ADDR, 8'h00, q);
        chk(q, 32'h0000_0002);
        chk(mon_en, 1'b0);
        acc(1'b0, 10'h004, 8'h00, q);
        chk(q, 32'h0000_0000);
        wait_rst(1'b0);
        acc(1'b1, REG_ADDR, 8'h80, q);
        acc(1'b0, REG_ADDR, 8'h00, q);
        chk(q, 32'h0000_0002);
        $display("power-on done");
        foreach (ROWS[i]) run_row(ROWS[i]);
        // monitor already on: writing it again must not reset; a running clock keeps the detector quiet
        acc(1'b1, REG_ADDR, 8'h06, q);
        repeat (80) @(negedge sys_clk);
        chk(sys_reset, 1'b0);
        run_row('{4'h0, 8'h12, 8'h10, 1'b0});
        chk(mon_en, 1'b1);
        // power-on in mid-run turns the monitor off again
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        acc(1'b0, REG_ADDR, 8'h00, q);
        chk(q, 32'h0000_0002);
        chk(mon_en, 1'b0);
        wait_rst(1'b0);
        $display("mid-run reset done");
        // monitor, comparator and clock detector off, flash write without program enable, read at the limit: nothing may reset
        acc(1'b1, REG_ADDR, 8'h00, q);
        vdd_low <= 1'b1;
        cmp_out <= 1'b0;
        clk_run <= 1'b0;
        fa <= '{movx_write: 1'b1, movx_addr: 16'h1e00, movc_read: 1'b1, movc_addr: LIMIT_8K, default: '0};
        @(posedge sys_clk);
        fa <= '0;
        repeat (80) @(negedge sys_clk);
        chk(sys_reset, 1'b0);
        chk(mon_en, 1'b0);
        $display("disabled sources done");
        results();
    end
endmodule
